// ==== src/ddr_strobe_consts.svh ====
// Constants for the strobe phase capture block
`ifndef DDR_STROBE_CONSTS_SVH
`define DDR_STROBE_CONSTS_SVH

`define DQ_W              32
`define WORD_W            64
`define PHASE_W           8
`define STROBES_PER_SIDE  10
`define SIDE_COUNT        2
`define SIDE_TOP          1'h0
`define SIDE_BOTTOM       1'h1
`define LOCK_CYCLES       256
`define LOCK_CNT_W        8
`define LOCK_LAST         8'hFF
`define PHASE_RESET       8'h00
`define CFG_W             20
`define CFG_TOP_LSB       12
`define CFG_BOT_LSB       4
`define CFG_SIDE_BIT      3
`define CFG_BANK_BIT      2
`define CFG_MODE_LSB      0
`define BUF_DEPTH         2

`endif

// ==== src/ddr_strobe_pkg.sv ====
// Types for the strobe phase capture block
package ddr_strobe_pkg;
    typedef enum logic [1:0] {
        BUS_X8  = 2'b00,
        BUS_X16 = 2'b01,
        BUS_X32 = 2'b10
    } bus_mode_t;
endpackage : ddr_strobe_pkg

// ==== src/strobe_word_buf.sv ====
// Two-entry buffer for captured read words
`timescale 1ns/1ns
module strobe_word_buf #(
    parameter int W = 64
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] e0_q;
    logic [W-1:0] e1_q;
    logic         v0_q;
    logic         v1_q;
    logic         push;
    logic         pop;

    // Head entry is always e0, so the output is a plain register
    assign in_ready  = !v1_q;
    assign out_valid = v0_q;
    assign out_data  = e0_q;
    assign push      = in_valid && !v1_q;
    assign pop       = v0_q && out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            e0_q <= '0;
            e1_q <= '0;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end else if (pop) begin
            if (v1_q) begin
                e0_q <= e1_q;
                e1_q <= in_data;
                v1_q <= push;
            end else begin
                e0_q <= in_data;
                v0_q <= push;
            end
        end else if (push) begin
            if (!v0_q) begin
                e0_q <= in_data;
                v0_q <= 1'b1;
            end else begin
                e1_q <= in_data;
                v1_q <= 1'b1;
            end
        end
    end
endmodule : strobe_word_buf

// ==== src/ddr_strobe_phase_capture.sv ====
// Strobe-based double-rate capture with two phase-shift reference circuits
`include "ddr_strobe_consts.svh"
`timescale 1ns/1ns
module ddr_strobe_phase_capture (
    input  wire logic                                     sys_clk,
    input  wire logic                                     sys_rst,
    input  wire logic                                     ref_clk,
    input  wire logic [`PHASE_W-1:0]                      top_phase_sel,
    input  wire logic [`PHASE_W-1:0]                      bot_phase_sel,
    input  wire logic                                     side_bank_mode,
    input  wire logic                                     bank_sel,
    input  wire logic [1:0]                               bus_mode,
    input  wire logic                                     dqs_in,
    input  wire logic [`DQ_W-1:0]                         dq_in,
    output logic [`DQ_W-1:0]                              dq_out,
    output logic [`DQ_W-1:0]                              dq_oe,
    input  wire logic                                     rd_en,
    input  wire logic [`DQ_W-1:0]                         wr_hi,
    input  wire logic [`DQ_W-1:0]                         wr_lo,
    input  wire logic                                     wr_ce,
    input  wire logic                                     wr_oe,
    output logic [`STROBES_PER_SIDE*`PHASE_W-1:0]         tap_top,
    output logic [`STROBES_PER_SIDE*`PHASE_W-1:0]         tap_bot,
    output logic                                          rd_valid,
    input  wire logic                                     rd_ready,
    output logic [`WORD_W-1:0]                            rd_data,
    output logic                                          top_locked,
    output logic                                          bot_locked,
    output logic                                          overrun
);
    // Lane mask for the selected data bus width
    function automatic logic [`DQ_W-1:0] lane_mask(input logic [1:0] mode);
        unique case (ddr_strobe_pkg::bus_mode_t'(mode))
            ddr_strobe_pkg::BUS_X8:  lane_mask = 32'h000000FF;
            ddr_strobe_pkg::BUS_X16: lane_mask = 32'h0000FFFF;
            default:                 lane_mask = 32'hFFFFFFFF;
        endcase
    endfunction : lane_mask

    // Link-domain reset: asserts at once, releases on ref_clk
    logic                     lrst_s1_q;
    logic                     lrst_s2_q;
    logic                     link_rst;
    logic [`CFG_W-1:0]        cfg_s1_q;
    logic [`CFG_W-1:0]        cfg_s2_q;
    logic                     dqs_s1_q;
    logic                     dqs_s2_q;
    logic [`LOCK_CNT_W-1:0]   cnt_q  [`SIDE_COUNT];
    logic [`PHASE_W-1:0]      tgt_q  [`SIDE_COUNT];
    logic [`SIDE_COUNT-1:0]   lock_q;
    logic [`PHASE_W-1:0]      tap_q  [`SIDE_COUNT][`STROBES_PER_SIDE];
    logic [`DQ_W-1:0]         rise_q;
    logic [`DQ_W-1:0]         fall_q;
    logic [`DQ_W-1:0]         hi_hold_q;
    logic [`WORD_W-1:0]       word_q;
    logic                     req_q;
    logic                     ack_s1_q;
    logic                     ack_s2_q;
    logic                     ovr_q;
    logic                     strobe_ok;
    logic                     busy;
    logic [`DQ_W-1:0]         mask;
    logic [`DQ_W-1:0]         out_hi_q;
    logic [`DQ_W-1:0]         out_lo_q;
    logic [`DQ_W-1:0]         lo_drive_q;
    logic                     oe_q;
    logic                     oe_drive_q;
    logic                     req_s1_q;
    logic                     req_s2_q;
    logic                     req_s3_q;
    logic                     pending_q;
    logic                     ack_q;
    logic                     buf_ready;
    logic [`SIDE_COUNT-1:0]   lk_s1_q;
    logic [`SIDE_COUNT-1:0]   lk_s2_q;
    logic                     ovr_s1_q;
    logic                     ovr_s2_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lrst_s1_q <= 1'b1;
            lrst_s2_q <= 1'b1;
        end else begin
            lrst_s1_q <= 1'b0;
            lrst_s2_q <= lrst_s1_q;
        end
    end
    assign link_rst = lrst_s2_q;

    // Quasi-static settings cross by two flops; change them only while no read runs
    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            cfg_s1_q <= '0;
            cfg_s2_q <= '0;
        end else begin
            cfg_s1_q <= {top_phase_sel, bot_phase_sel, side_bank_mode, bank_sel, bus_mode};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // Strobe pin level, two flops before use
    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            dqs_s1_q <= 1'b0;
            dqs_s2_q <= 1'b0;
        end else begin
            dqs_s1_q <= dqs_in;
            dqs_s2_q <= dqs_s1_q;
        end
    end

    // One reference circuit per side, each with its own target phase
    for (genvar s = 0; s < `SIDE_COUNT; s++) begin : g_side
        logic [`PHASE_W-1:0] want;
        assign want = (s == 0) ? cfg_s2_q[`CFG_TOP_LSB +: `PHASE_W]
                               : cfg_s2_q[`CFG_BOT_LSB +: `PHASE_W];

        always_ff @(posedge ref_clk or posedge link_rst) begin
            if (link_rst) begin
                cnt_q[s]  <= '0;
                tgt_q[s]  <= `PHASE_RESET;
                lock_q[s] <= 1'b0;
            end else if (want != tgt_q[s]) begin
                // A new phase restarts the settling count on this side only
                tgt_q[s]  <= want;
                cnt_q[s]  <= '0;
                lock_q[s] <= 1'b0;
            end else if (!lock_q[s]) begin
                if (cnt_q[s] == `LOCK_LAST) begin
                    lock_q[s] <= 1'b1;
                end else begin
                    cnt_q[s] <= cnt_q[s] + 1'b1;
                end
            end
        end

        // Every delay element of a side takes the identical code
        for (genvar e = 0; e < `STROBES_PER_SIDE; e++) begin : g_elem
            always_ff @(posedge ref_clk or posedge link_rst) begin
                if (link_rst) begin
                    tap_q[s][e] <= `PHASE_RESET;
                end else if (!lock_q[s] && cnt_q[s] == `LOCK_LAST) begin
                    tap_q[s][e] <= tgt_q[s];
                end
            end
        end
    end

    for (genvar e = 0; e < `STROBES_PER_SIDE; e++) begin : g_tap_out
        assign tap_top[e*`PHASE_W +: `PHASE_W] = tap_q[0][e];
        assign tap_bot[e*`PHASE_W +: `PHASE_W] = tap_q[1][e];
    end

    // Double-rate capture on the strobe-aligned clock
    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            rise_q <= '0;
        end else begin
            rise_q <= dq_in;
        end
    end

    // Falling edge takes the second bit and holds the high-phase bit
    always_ff @(negedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            fall_q    <= '0;
            hi_hold_q <= '0;
        end else begin
            fall_q    <= dq_in;
            hi_hold_q <= rise_q;
        end
    end

    // Side banks have no phase hardware, so the strobe and lock are not consulted
    assign strobe_ok = cfg_s2_q[`CFG_SIDE_BIT] ? 1'b1
                     : (dqs_s2_q && lock_q[cfg_s2_q[`CFG_BANK_BIT]]);
    assign busy      = req_q != ack_s2_q;
    assign mask      = lane_mask(cfg_s2_q[`CFG_MODE_LSB +: 2]);

    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Word is held stable until the system side acknowledges it
    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            word_q <= '0;
            req_q  <= 1'b0;
            ovr_q  <= 1'b0;
        end else if (rd_en && strobe_ok) begin
            if (busy) begin
                ovr_q <= 1'b1;
            end else begin
                word_q <= {hi_hold_q & mask, fall_q & mask};
                req_q  <= ~req_q;
            end
        end
    end

    // Double-rate output registers, updated only under the clock enable
    always_ff @(posedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            out_hi_q <= '0;
            out_lo_q <= '0;
            oe_q     <= 1'b0;
        end else if (wr_ce) begin
            out_hi_q <= wr_hi;
            out_lo_q <= wr_lo;
            oe_q     <= wr_oe;
        end
    end

    // Enable waits for the falling edge, as the memory bus timing needs
    always_ff @(negedge ref_clk or posedge link_rst) begin
        if (link_rst) begin
            lo_drive_q <= '0;
            oe_drive_q <= 1'b0;
        end else begin
            lo_drive_q <= out_lo_q;
            oe_drive_q <= oe_q;
        end
    end

    // Clock picks the high-phase bit, then the low-phase bit
    assign dq_out = ref_clk ? out_hi_q : lo_drive_q;
    assign dq_oe  = {`DQ_W{oe_drive_q}};

    // System side of the word handshake
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // A stalled buffer keeps the acknowledge back, so word_q is not overwritten; a capture meanwhile is dropped and sets overrun
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_q <= 1'b0;
            ack_q     <= 1'b0;
        end else if (req_s2_q != req_s3_q) begin
            pending_q <= 1'b1;
        end else if (pending_q && buf_ready) begin
            pending_q <= 1'b0;
            ack_q     <= ~ack_q;
        end
    end

    strobe_word_buf #(
        .W         (`WORD_W)
    ) u_buf (
        .clk       (sys_clk),
        .rst       (sys_rst),
        .in_valid  (pending_q),
        .in_ready  (buf_ready),
        .in_data   (word_q),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // Status levels into the system domain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_s1_q  <= '0;
            lk_s2_q  <= '0;
            ovr_s1_q <= 1'b0;
            ovr_s2_q <= 1'b0;
        end else begin
            lk_s1_q  <= lock_q;
            lk_s2_q  <= lk_s1_q;
            ovr_s1_q <= ovr_q;
            ovr_s2_q <= ovr_s1_q;
        end
    end

    assign top_locked = lk_s2_q[0];
    assign bot_locked = lk_s2_q[1];
    assign overrun    = ovr_s2_q;
endmodule : ddr_strobe_phase_capture

// ==== verification/strobe_capture_props.sv ====
// Port assertions for the strobe phase capture block
`timescale 1ns/1ns
module strobe_capture_props (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        ref_clk,
    input wire logic [7:0]  top_phase_sel,
    input wire logic [7:0]  bot_phase_sel,
    input wire logic        side_bank_mode,
    input wire logic        bank_sel,
    input wire logic [31:0] dq_out,
    input wire logic [31:0] dq_oe,
    input wire logic [31:0] wr_hi,
    input wire logic [31:0] wr_lo,
    input wire logic        wr_ce,
    input wire logic        wr_oe,
    input wire logic [79:0] tap_top,
    input wire logic [79:0] tap_bot,
    input wire logic        rd_valid,
    input wire logic        top_locked,
    input wire logic        bot_locked
);
    logic        ce_q;
    logic        oe_q;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic [7:0]  wait_q;
    // Mirror of the load taken at each rising edge, so both phases can be checked
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            ce_q <= 1'h0;
        else
            ce_q <= wr_ce;
    end
    always_ff @(posedge ref_clk) begin
        hi_q <= wr_hi;
        lo_q <= wr_lo;
        oe_q <= wr_oe;
    end
    // Unlocked system cycles since the last code change; covers link reset and syncs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            wait_q <= 8'h00;
        else if (top_locked || $changed(top_phase_sel))
            wait_q <= 8'h00;
        else
            wait_q <= wait_q + 8'h01;
    end
    same_taps_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tap_top == {10{tap_top[7:0]}} && tap_bot == {10{tap_bot[7:0]}}) else $error("taps differ");
    high_phase_a: assert property (@(negedge ref_clk) disable iff (sys_rst)
        ce_q |-> dq_out == hi_q) else $error("high phase bit wrong");
    out_hold_a: assert property (@(negedge ref_clk) disable iff (sys_rst)
        !ce_q |-> $stable(dq_out)) else $error("output changed without enable");
    low_phase_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ce_q |-> dq_out == lo_q && dq_oe == {32{oe_q}}) else $error("low phase bit wrong");
    lock_taps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(top_locked) |-> tap_top == {10{top_phase_sel}}) else $error("locked on wrong taps");
    lock_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wait_q <= 8'hB9) else $error("lock too slow");
    side_indep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(top_phase_sel) && $stable(bot_phase_sel) && bot_locked |=> bot_locked [*8])
        else $error("bottom side disturbed");
    gate_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(rd_valid) && !side_bank_mode |-> (bank_sel ? bot_locked : top_locked))
        else $error("capture while unlocked");
endmodule : strobe_capture_props

bind ddr_strobe_phase_capture strobe_capture_props chk_u (.sys_clk, .sys_rst, .ref_clk,
    .top_phase_sel, .bot_phase_sel, .side_bank_mode, .bank_sel, .dq_out, .dq_oe, .wr_hi,
    .wr_lo, .wr_ce, .wr_oe, .tap_top, .tap_bot, .rd_valid, .top_locked, .bot_locked);

// ==== verification/ddr_mem_model.sv ====
// Read side of the external double-rate memory
`timescale 1ns/1ns
module ddr_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        drive,
    input  wire logic        strobe_on,
    input  wire logic [31:0] hi,
    input  wire logic [31:0] lo,
    output logic             dqs,
    output logic [31:0]      dq
);
    initial dq = 32'h0;
    // Paced by the reference clock, so strobe and reference share one rate
    always @(negedge ref_clk) dq <= drive ? hi : ~dq;
    always @(posedge ref_clk) dq <= drive ? lo : ~dq;
    // Strobe held through a burst only; idle strobe is terminated low
    assign dqs = drive && strobe_on;
endmodule : ddr_mem_model

// ==== verification/tb_ddr_strobe_phase_capture.sv ====
// Self-checking bench for the strobe phase capture block
`timescale 1ns/1ns
module tb_ddr_strobe_phase_capture;
    logic        sys_clk, sys_rst, ref_clk, side_bank_mode, bank_sel, rd_en, wr_ce, wr_oe;
    logic        rd_ready, rd_valid, top_locked, bot_locked, overrun, dqs_in, drive, strobe_on;
    logic [1:0]  bus_mode;
    logic [7:0]  top_phase_sel, bot_phase_sel;
    logic [31:0] dq_in, dq_out, dq_oe, wr_hi, wr_lo, hi, lo, m;
    logic [79:0] tap_top, tap_bot;
    logic [63:0] rd_data;
    logic [63:0] exp_q[$];
    int          n_errors = 0, checked = 0, seed = 32'h68bb;

    initial sys_clk = 1'h0;
    always #50 sys_clk = ~sys_clk;
    initial begin
        ref_clk = 1'h0;
        #5;
        forever #32 ref_clk = ~ref_clk;
    end

    ddr_strobe_phase_capture dut_u (.sys_clk, .sys_rst, .ref_clk, .top_phase_sel,
        .bot_phase_sel, .side_bank_mode, .bank_sel, .bus_mode, .dqs_in, .dq_in, .dq_out,
        .dq_oe, .rd_en, .wr_hi, .wr_lo, .wr_ce, .wr_oe, .tap_top, .tap_bot, .rd_valid,
        .rd_ready, .rd_data, .top_locked, .bot_locked, .overrun);
    ddr_mem_model mem_u (.ref_clk, .drive, .strobe_on, .hi, .lo, .dqs(dqs_in), .dq(dq_in));

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // One read burst from the memory with a single capture request in it
    task automatic grab(input logic take);
        @(negedge ref_clk);
        hi = $random(seed);
        lo = $random(seed);
        drive = 1'h1;
        m = bus_mode == 2'h0 ? 32'h0000_00FF : bus_mode == 2'h1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        if (take)
            exp_q.push_back({hi & m, lo & m});
        repeat (4) @(negedge ref_clk);
        rd_en = 1'h1;
        @(negedge ref_clk) rd_en = 1'h0;
        repeat (12) @(negedge ref_clk);
        drive = 1'h0;
    endtask : grab

    task automatic pop;
        // Let an edge pass so back-to-back pops never set rd_ready twice at once
        @(negedge sys_clk);
        for (int i = 0; i < 60 && rd_valid !== 1'h1; i++) @(negedge sys_clk);
        check(rd_data, exp_q.pop_front());
        rd_ready = 1'h1;
        @(negedge sys_clk) rd_ready = 1'h0;
    endtask : pop

    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        {side_bank_mode, bank_sel, rd_en, wr_ce, wr_oe, rd_ready, drive} = 7'h00;
        {strobe_on, bus_mode, top_phase_sel, bot_phase_sel} = 19'h40000;
        {wr_hi, wr_lo} = 64'h0;
        sys_rst = 1'h1;
        repeat (20) @(negedge sys_clk);
        check({rd_valid, top_locked, dq_oe, tap_top[31:0]}, 66'h0);
        sys_rst = 1'h0;
        top_phase_sel = $random(seed);
        bot_phase_sel = top_phase_sel ^ 8'h5A;
        repeat (200) @(negedge sys_clk);
        check(tap_top, {10{top_phase_sel}});
        check(tap_bot, {10{bot_phase_sel}});
        check({top_locked, bot_locked}, 2'h3);
        $display("lock test done");
        top_phase_sel = ~top_phase_sel;
        repeat (200) @(negedge sys_clk);
        check(tap_top, {10{top_phase_sel}});
        check(tap_bot, {10{bot_phase_sel}});
        check({top_locked, bot_locked}, 2'h3);
        $display("side test done");
        @(negedge ref_clk);
        wr_hi = $random(seed);
        wr_lo = $random(seed);
        {wr_ce, wr_oe} = 2'h3;
        @(posedge ref_clk) #16 check(dq_out, wr_hi);
        @(negedge ref_clk) hi = wr_hi;
        wr_ce = 1'h0;
        wr_hi = ~wr_hi;
        #16 check({dq_out, dq_oe}, {wr_lo, 32'hFFFF_FFFF});
        @(posedge ref_clk) #16 check(dq_out, hi);
        $display("output test done");
        for (int k = 0; k < 4; k++) begin
            bus_mode = k[1:0];
            bank_sel = k[0];
            grab(1'h1);
            pop();
        end
        strobe_on = 1'h0;
        grab(1'h0);
        repeat (20) @(negedge sys_clk);
        check(rd_valid, 1'h0);
        side_bank_mode = 1'h1;
        grab(1'h1);
        pop();
        $display("capture test done");
        {side_bank_mode, strobe_on} = 2'h1;
        // Two words fill the buffer, a third waits unacknowledged, the fourth is refused
        repeat (3) grab(1'h1);
        grab(1'h0);
        check(overrun, 1'h1);
        pop();
        pop();
        pop();
        rd_ready = 1'h1;
        repeat (20) @(negedge sys_clk);
        check(rd_valid, 1'h0);
        check(exp_q.size(), 0);
        $display("buffer test done");
        report_and_stop();
    end
endmodule : tb_ddr_strobe_phase_capture
